// [inc/sibw_defs.svh]
`ifndef SIBW_DEFS_SVH
`define SIBW_DEFS_SVH

// Register indexes; byte address is four times the index
`define SIBW_IDX_BRK_STAT   16'hFE00
`define SIBW_IDX_BRK_CTRL   16'hFE03
`define SIBW_IDX_FLAGS_LOW  16'hFE04
`define SIBW_IDX_FLAGS_MID  16'hFE05
`define SIBW_IDX_FLAGS_HIGH 16'hFE06

// Bus geometry
`define SIBW_ADR_W          18
`define SIBW_IDX_LSB        2
`define SIBW_DAT_W          32
`define SIBW_REG_W          8

// Field positions
`define SIBW_BIT_STOP_WAIT  1
`define SIBW_BIT_CLR_EN     7

// Status register packing
`define SIBW_LOW_SRC_LSB    0
`define SIBW_LOW_SRC_MSB    5
`define SIBW_MID_SRC_LSB    6
`define SIBW_MID_SRC_MSB    13
`define SIBW_HIGH_SRC_LSB   14
`define SIBW_HIGH_SRC_MSB   19

// Source count and vector encodings
`define SIBW_NUM_SRC        20
`define SIBW_VEC_W          5
`define SIBW_VEC_TRAP       5'h00

// Reset values
`define SIBW_RST_BYTE       8'h00
`define SIBW_RST_WORD       32'h0000_0000

`endif

// [inc/sibw_pkg.sv]
`include "sibw_defs.svh"

package sibw_pkg;

    // Controller states, one-hot
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_WAIT = 3'b010,
        ST_SVC  = 3'b100
    } sibw_state_e;

    // Events reported by the processor core
    typedef struct packed {
        logic instrDone;
        logic trapExec;
        logic waitExec;
        logic stopExec;
        logic vecFetched;
    } sibw_core_evt_s;

    // Interrupt entry order handed to the core
    typedef struct packed {
        logic                    take;
        logic                    pcMinusOne;
        logic                    stackHigh;
        logic [`SIBW_VEC_W-1:0] vecSel;
    } sibw_entry_s;

endpackage : sibw_pkg

// [rtl/sibw_arbiter.sv]
`timescale 1ns/1ns
`include "sibw_defs.svh"

module sibw_arbiter #(
    parameter int NUM_SRC = `SIBW_NUM_SRC
) (
    input  wire logic [NUM_SRC-1:0]     reqMasked,
    output logic                        anyReq,
    output logic [`SIBW_VEC_W-1:0]      winner
);

    logic [NUM_SRC-1:0] lowerFree;

    // Refuse a source count the vector field cannot carry
    if (NUM_SRC < 1 || NUM_SRC >= (1 << `SIBW_VEC_W)) begin : g_chk
        $error("sibw_arbiter: NUM_SRC out of range");
    end

    // Bit i wins when no lower-index (higher-priority) source asks
    assign lowerFree[0] = 1'b1;
    for (genvar i = 1; i < NUM_SRC; i++) begin : g_free
        assign lowerFree[i] = lowerFree[i-1] & ~reqMasked[i-1];
    end

    // Vector code is source number, one above the bit index
    always_comb begin
        winner = `SIBW_VEC_TRAP;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (reqMasked[i] && lowerFree[i]) begin
                winner = `SIBW_VEC_W'(i + 1);
            end
        end
    end

    assign anyReq = |reqMasked;

endmodule : sibw_arbiter

// [rtl/sibw_top.sv]
`timescale 1ns/1ns
`include "sibw_defs.svh"

// Notes on behaviour
// - Hardware interrupts wait for instruction completion
// - Enter only when unmasked and source enabled
// - Highest priority pending request served first
// - Pending request served right after return
// - High index register is never stacked
// - Software trap ignores the global mask
// - Trap stacks PC, hardware stacks PC-1
// - Fixed priority order, source one highest
// - Low flags: sources 6-1 in bits 7:2
// - Mid flags: sources 14-7 in bits 7:0
// - High flags: sources 20-15 in bits 5:0
// - Flag mirrors request presence, resets zero
// - Reset overrides everything, no arbitration
// - Break forces fetch of trap vector
// - Break blocks flag clears unless enabled
// - Flags cleared in break stay cleared
// - Two-step clears stay blocked during break unless enabled
// - Wait or stop clears the global mask
// - Wait stops core clocks, peripherals run
// - Enabled interrupt wakes core, stacks next cycle
// - Break or reset also ends wait
// - Watchdog runs in wait unless disabled
// - Latched interrupt holds until serviced
module sibw_top #(
    parameter int NUM_SRC = `SIBW_NUM_SRC
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // Classic Wishbone slave
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [`SIBW_ADR_W-1:0]      adr_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [`SIBW_DAT_W-1:0]      dat_i,
    output logic                             ack_o,
    output logic [`SIBW_DAT_W-1:0]           dat_o,
    // Processor core
    input  wire sibw_pkg::sibw_core_evt_s    coreEvt,
    input  wire logic                        intMask,
    output sibw_pkg::sibw_entry_s            entry,
    output logic                             maskClear,
    output logic                             cpuClkEn,
    output logic                             periphClkEn,
    // Peripherals and break module
    input  wire logic [NUM_SRC-1:0]          srcReq,
    input  wire logic [NUM_SRC-1:0]          srcEn,
    input  wire logic                        breakReq,
    input  wire logic                        watchdogDisableOpt,
    output logic                             watchdogEn,
    output logic                             breakActive,
    output logic                             flagClearEn
);

    sibw_pkg::sibw_state_e            state_reg;
    sibw_pkg::sibw_state_e            state_next;
    sibw_pkg::sibw_entry_s            entry_next;
    logic [NUM_SRC-1:0]               srcFlags_reg;
    logic                             clrEnable_reg;
    logic                             stopWait_reg;
    logic                             intMaskPrev_reg;
    logic                             breakState_reg;
    logic                             anyReq;
    logic [`SIBW_VEC_W-1:0]           winner;
    logic                             hwTake;
    logic                             maskFell;
    logic                             busHit;
    logic [`SIBW_ADR_W-`SIBW_IDX_LSB-1:0] regIdx;
    logic [`SIBW_REG_W-1:0]           rdByte;
    logic                             wrByte;

    // The count must match the three status registers
    if (NUM_SRC != `SIBW_NUM_SRC) begin : g_chk
        $error("sibw_top: NUM_SRC must equal the status field width");
    end

    // Fixed-priority pick among enabled, pending sources
    sibw_arbiter #(
        .NUM_SRC   (NUM_SRC)
    ) u_arb (
        .reqMasked (srcReq & srcEn),
        .anyReq    (anyReq),
        .winner    (winner)
    );

    // Hardware entry needs both the source enable and a clear mask
    assign hwTake   = anyReq && !intMask;
    assign maskFell = intMaskPrev_reg && !intMask;

    // Core mask history, to see the mask being cleared
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            intMaskPrev_reg <= 1'b1;
        end else begin
            intMaskPrev_reg <= intMask;
        end
    end

    // Sequencing: decide only at boundaries, in wait, or on break
    always_comb begin
        state_next            = state_reg;
        entry_next            = entry;
        entry_next.take       = 1'b0;
        entry_next.stackHigh  = 1'b0;
        unique case (state_reg)
            sibw_pkg::ST_RUN: begin
                if (breakReq) begin
                    // Break rides on the trap vector
                    state_next            = sibw_pkg::ST_SVC;
                    entry_next.take       = 1'b1;
                    entry_next.vecSel     = `SIBW_VEC_TRAP;
                    entry_next.pcMinusOne = 1'b0;
                end else if (coreEvt.instrDone) begin
                    if (coreEvt.trapExec) begin
                        // Mask not consulted for the trap
                        state_next            = sibw_pkg::ST_SVC;
                        entry_next.take       = 1'b1;
                        entry_next.vecSel     = `SIBW_VEC_TRAP;
                        entry_next.pcMinusOne = 1'b0;
                    end else if (coreEvt.waitExec) begin
                        state_next = sibw_pkg::ST_WAIT;
                    end else if (hwTake) begin
                        state_next            = sibw_pkg::ST_SVC;
                        entry_next.take       = 1'b1;
                        entry_next.vecSel     = winner;
                        entry_next.pcMinusOne = 1'b1;
                    end
                end
            end
            sibw_pkg::ST_WAIT: begin
                if (breakReq) begin
                    state_next            = sibw_pkg::ST_SVC;
                    entry_next.take       = 1'b1;
                    entry_next.vecSel     = `SIBW_VEC_TRAP;
                    entry_next.pcMinusOne = 1'b0;
                end else if (hwTake) begin
                    // Take pulses one cycle after the request shows
                    state_next            = sibw_pkg::ST_SVC;
                    entry_next.take       = 1'b1;
                    entry_next.vecSel     = winner;
                    entry_next.pcMinusOne = 1'b1;
                end
            end
            sibw_pkg::ST_SVC: begin
                // Latched choice stays put whatever else arrives
                if (coreEvt.vecFetched || maskFell) begin
                    state_next = sibw_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = sibw_pkg::ST_RUN;
            end
        endcase
    end

    // State and entry order; reset forces all idle at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg         <= sibw_pkg::ST_RUN;
            entry.take        <= 1'b0;
            entry.pcMinusOne  <= 1'b0;
            entry.stackHigh   <= 1'b0;
            entry.vecSel      <= `SIBW_VEC_TRAP;
        end else begin
            state_reg <= state_next;
            entry     <= entry_next;
        end
    end

    // Clock gating: core stops in wait, peripherals never do
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpuClkEn    <= 1'b1;
            periphClkEn <= 1'b1;
        end else begin
            cpuClkEn    <= (state_next != sibw_pkg::ST_WAIT);
            periphClkEn <= 1'b1;
        end
    end

    // Low-power instructions open the mask for wakeup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            maskClear <= 1'b0;
        end else begin
            maskClear <= coreEvt.instrDone
                         && (coreEvt.waitExec || coreEvt.stopExec);
        end
    end

    // Watchdog keeps running through wait when not disabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            watchdogEn <= 1'b0;
        end else begin
            watchdogEn <= !watchdogDisableOpt;
        end
    end

    // Break state lasts from break entry until a trap instruction completes with break released
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            breakState_reg <= 1'b0;
        end else if (entry_next.take && breakReq) begin
            breakState_reg <= 1'b1;
        end else if (breakState_reg && coreEvt.trapExec
                     && coreEvt.instrDone && !breakReq) begin
            breakState_reg <= 1'b0;
        end
    end

    // Peripherals clear flags only outside break, or when enabled;
    // a flag cleared here is simply gone afterwards, and the second
    // step of a two-step clear is gated the same way
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            breakActive <= 1'b0;
            flagClearEn <= 1'b1;
        end else begin
            breakActive <= breakState_reg;
            flagClearEn <= !breakState_reg || clrEnable_reg;
        end
    end

    // Request mirror, sampled every cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            srcFlags_reg <= '0;
        end else begin
            srcFlags_reg <= srcReq;
        end
    end

    // Bus decode: word per register, index in the upper address bits
    assign regIdx = adr_i[`SIBW_ADR_W-1:`SIBW_IDX_LSB];
    assign busHit = cyc_i && stb_i && !ack_o;
    // Write lands at the edge where the master samples ack high
    assign wrByte = cyc_i && stb_i && ack_o && we_i && sel_i[0];

    // Read data assembly; unmapped indexes read zero
    always_comb begin
        rdByte = `SIBW_RST_BYTE;
        unique case (regIdx)
            `SIBW_IDX_FLAGS_LOW: begin
                rdByte = {srcFlags_reg[`SIBW_LOW_SRC_MSB:
                                       `SIBW_LOW_SRC_LSB], 2'b00};
            end
            `SIBW_IDX_FLAGS_MID: begin
                rdByte = srcFlags_reg[`SIBW_MID_SRC_MSB:
                                      `SIBW_MID_SRC_LSB];
            end
            `SIBW_IDX_FLAGS_HIGH: begin
                rdByte = {2'b00, srcFlags_reg[`SIBW_HIGH_SRC_MSB:
                                              `SIBW_HIGH_SRC_LSB]};
            end
            `SIBW_IDX_BRK_STAT: begin
                rdByte[`SIBW_BIT_STOP_WAIT] = stopWait_reg;
            end
            `SIBW_IDX_BRK_CTRL: begin
                rdByte[`SIBW_BIT_CLR_EN] = clrEnable_reg;
            end
            default: begin
                rdByte = `SIBW_RST_BYTE;
            end
        endcase
    end

    // One-cycle answer to every access, mapped or not
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= `SIBW_RST_WORD;
        end else begin
            ack_o <= busHit;
            if (busHit && !we_i) begin
                dat_o <= {{(`SIBW_DAT_W-`SIBW_REG_W){1'b0}}, rdByte};
            end
        end
    end

    // Clear-enable control bit; flag registers have no write path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clrEnable_reg <= 1'b0;
        end else if (wrByte && regIdx == `SIBW_IDX_BRK_CTRL) begin
            clrEnable_reg <= dat_i[`SIBW_BIT_CLR_EN];
        end
    end

    // Break-out-of-wait flag: hardware set beats a software clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stopWait_reg <= 1'b0;
        end else if (state_reg == sibw_pkg::ST_WAIT && breakReq) begin
            stopWait_reg <= 1'b1;
        end else if (wrByte && regIdx == `SIBW_IDX_BRK_STAT
                     && !dat_i[`SIBW_BIT_STOP_WAIT]) begin
            stopWait_reg <= 1'b0;
        end
    end

endmodule : sibw_top

// [dv/sibw_top_sva.sv]
`timescale 1ns/1ns
`include "sibw_defs.svh"
module sibw_top_sva #(
    parameter int NUM_SRC = `SIBW_NUM_SRC
) (
    input logic                     mclk,
    input logic                     rst_n,
    input logic                     cyc_i,
    input logic                     stb_i,
    input logic                     ack_o,
    input sibw_pkg::sibw_core_evt_s coreEvt,
    input logic                     intMask,
    input sibw_pkg::sibw_entry_s    entry,
    input logic                     maskClear,
    input logic                     cpuClkEn,
    input logic                     periphClkEn,
    input logic [NUM_SRC-1:0]       srcReq,
    input logic [NUM_SRC-1:0]       srcEn,
    input logic                     watchdogDisableOpt,
    input logic                     watchdogEn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [NUM_SRC-1:0] prevReq_reg;
    logic               prevMask_reg;
    logic               held_reg;
    logic [4:0]         idx;
    // Inputs as the arbiter sampled them at the deciding edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prevReq_reg  <= '0;
            prevMask_reg <= 1'b1;
        end else begin
            prevReq_reg  <= srcReq & srcEn;
            prevMask_reg <= intMask;
        end
    end
    // Latch window; opens one edge late, so the take that starts it is not flagged
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) held_reg <= 1'b0;
        else if (entry.take) held_reg <= 1'b1;
        else if (coreEvt.vecFetched || $fell(intMask)) held_reg <= 1'b0;
    end
    assign idx = entry.vecSel - 5'h1;
    sequence s_hwTake; entry.take && entry.pcMinusOne; endsequence
    sequence s_waitIn; coreEvt.instrDone && coreEvt.waitExec; endsequence
    sequence s_wakeCause; !cpuClkEn && !intMask && |(srcReq & srcEn);
    endsequence
    property p_ackNext; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    property p_noHigh; !entry.stackHigh; endproperty
    property p_pcKind;
        entry.take |-> entry.pcMinusOne == (entry.vecSel != 5'h0);
    endproperty
    property p_hwCause; s_hwTake |-> !prevMask_reg && prevReq_reg[idx];
    endproperty
    property p_hwPrio;
        s_hwTake |-> (prevReq_reg & ((NUM_SRC'(1) << idx) - NUM_SRC'(1))) == '0;
    endproperty
    property p_boundary;
        s_hwTake |-> $past(coreEvt.instrDone) || !$past(cpuClkEn);
    endproperty
    property p_maskClr;
        coreEvt.instrDone && (coreEvt.waitExec || coreEvt.stopExec) |=> maskClear;
    endproperty
    property p_waitIn; s_waitIn |=> !cpuClkEn && periphClkEn; endproperty
    property p_wake; s_wakeCause |=> entry.take && cpuClkEn; endproperty
    property p_watchdog;
        $past(rst_n) |-> watchdogEn == !$past(watchdogDisableOpt);
    endproperty
    property p_latch; held_reg |-> !entry.take; endproperty
    property p_trap;
        coreEvt.instrDone && coreEvt.trapExec && !held_reg
            |=> entry.take && entry.vecSel == 5'h0;
    endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack timing wrong");
    a_noHigh: assert property (p_noHigh) else $error("high stacked");
    a_pcKind: assert property (p_pcKind) else $error("pc kind wrong");
    a_hwCause: assert property (p_hwCause) else $error("bad entry");
    a_hwPrio: assert property (p_hwPrio) else $error("bad priority");
    a_boundary: assert property (p_boundary) else $error("mid instr");
    a_maskClr: assert property (p_maskClr) else $error("no unmask");
    a_waitIn: assert property (p_waitIn) else $error("bad clocks");
    a_wake: assert property (p_wake) else $error("no wakeup");
    a_watchdog: assert property (p_watchdog) else $error("wd en");
    a_latch: assert property (p_latch) else $error("latch broken");
    a_trap: assert property (p_trap) else $error("trap not taken");
endmodule : sibw_top_sva

bind sibw_top sibw_top_sva #(.NUM_SRC(NUM_SRC)) u_sva (
    .mclk(mclk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .coreEvt(coreEvt), .intMask(intMask), .entry(entry),
    .maskClear(maskClear), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .srcReq(srcReq), .srcEn(srcEn), .watchdogEn(watchdogEn),
    .watchdogDisableOpt(watchdogDisableOpt));

// [dv/sibw_core_model.sv]
`timescale 1ns/1ns
module sibw_core_model (
    input  logic                     mclk,
    input  logic                     rst_n,
    input  sibw_pkg::sibw_entry_s    entry,
    input  logic                     maskClear,
    input  logic                     cpuClkEn,
    input  logic [1:0]               op,
    input  logic                     opValid,
    input  logic                     slow,
    output sibw_pkg::sibw_core_evt_s coreEvt,
    output logic                     intMask,
    output logic                     opAck
);
    logic [3:0] phase_reg;
    logic       tick_reg;
    logic       savedMask_reg;
    // Two-cycle instructions, entry service, return restoring the mask
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            coreEvt       <= '0;
            intMask       <= 1'b1;
            opAck         <= 1'b0;
            phase_reg     <= 4'h0;
            tick_reg      <= 1'b0;
            savedMask_reg <= 1'b0;
        end else begin
            coreEvt <= '0;
            opAck   <= 1'b0;
            if (maskClear) intMask <= 1'b0;
            if (entry.take) begin
                savedMask_reg <= intMask;
                intMask       <= 1'b1;
                phase_reg     <= slow ? 4'hc : 4'h5;
            end else if (phase_reg != 4'h0) begin
                phase_reg          <= phase_reg - 4'h1;
                coreEvt.vecFetched <= phase_reg == 4'h4;
                coreEvt.instrDone  <= phase_reg == 4'h1;
                // Mask back before the return ends, so pending work chains
                if (phase_reg == 4'h2) intMask <= savedMask_reg;
            end else if (cpuClkEn) begin
                tick_reg <= !tick_reg;
                if (tick_reg) begin
                    coreEvt.instrDone <= 1'b1;
                    coreEvt.trapExec  <= opValid && op == 2'h1;
                    coreEvt.waitExec  <= opValid && op == 2'h2;
                    coreEvt.stopExec  <= opValid && op == 2'h3;
                    opAck             <= opValid;
                end
            end
        end
    end
endmodule : sibw_core_model

// [dv/sibw_top_test.sv]
`timescale 1ns/1ns
`include "sibw_defs.svh"
module sibw_top_test;
    logic                     mclk = 1'b0, rst_n = 1'b0;
    logic                     cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [`SIBW_ADR_W-1:0]   adr_i = '0;
    logic [`SIBW_DAT_W-1:0]   dat_i = '0, dat_o;
    logic [3:0]               sel_i = 4'h1;
    logic [19:0]              srcReq = '0, srcEn = '0, v;
    logic                     breakReq = 1'b0, wdOpt = 1'b0, slow = 1'b0;
    logic                     opValid = 1'b0;
    logic [1:0]               op = 2'h0;
    logic                     ack_o, intMask, maskClear, cpuClkEn, opAck;
    logic                     periphClkEn, watchdogEn, breakActive, clrEn;
    sibw_pkg::sibw_core_evt_s coreEvt;
    sibw_pkg::sibw_entry_s    entry;
    logic [15:0]              lfsr = 16'h42aa;
    logic [7:0]               expRd[$];
    logic [6:0]               expTake[$];
    logic [4:0]               lastVec = 5'h0;
    int                       errTotal = 0, checksDone = 0, cycles = 0;
    int                       a, b;
    always #25 mclk = !mclk;
    sibw_top dut (.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .ack_o(ack_o), .dat_o(dat_o), .coreEvt(coreEvt), .intMask(intMask),
        .entry(entry), .maskClear(maskClear), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .srcReq(srcReq), .srcEn(srcEn),
        .breakReq(breakReq), .watchdogDisableOpt(wdOpt),
        .watchdogEn(watchdogEn), .breakActive(breakActive),
        .flagClearEn(clrEn));
    sibw_core_model core (.mclk(mclk), .rst_n(rst_n), .entry(entry),
        .maskClear(maskClear), .cpuClkEn(cpuClkEn), .op(op),
        .opValid(opValid), .slow(slow), .coreEvt(coreEvt),
        .intMask(intMask), .opAck(opAck));
    task automatic chk(input string nm, input logic [31:0] e, g);
        checksDone++;
        if (g !== e) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic testDone();
        if (errTotal == 0 && checksDone > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : testDone
    // Held until the ack edge; read expectations queued up front
    task automatic bus(input logic wr, input logic [15:0] ix, logic [7:0] d);
        @(posedge mclk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= {ix, 2'b00};
        dat_i <= `SIBW_DAT_W'(d);
        if (!wr) expRd.push_back(d);
        do @(posedge mclk); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : bus
    task automatic doOp(input logic [1:0] c);
        @(posedge mclk);
        op      <= c;
        opValid <= 1'b1;
        do @(posedge mclk); while (opAck !== 1'b1);
        opValid <= 1'b0;
    endtask : doOp
    // Peripheral drops its line once its entry was seen
    task automatic waitTake(input int left);
        do @(posedge mclk); while (expTake.size() > left);
        if (lastVec != 5'h0) srcReq[lastVec - 5'h1] <= 1'b0;
    endtask : waitTake
    function automatic logic [15:0] lfsrStep(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrStep
    task automatic rnd();
        lfsr = lfsrStep(lfsr);
        v    = {lfsr[3:0], lfsr[15:4] ^ lfsr[11:0], lfsr[3:0]};
    endtask : rnd
    // Result watcher: read data at ack, entry orders at take
    always @(posedge mclk) begin
        cycles++;
        if (ack_o === 1'b1 && we_i === 1'b0)
            chk("dat_o", `SIBW_DAT_W'(expRd.pop_front()), dat_o);
        if (entry.take === 1'b1) begin
            lastVec = entry.vecSel;
            if (expTake.size() == 0) chk("take", 32'h0, 32'h1);
            else chk("entry", 32'(expTake.pop_front()),
                32'({entry.pcMinusOne, entry.stackHigh, entry.vecSel}));
        end
        if (cycles == 8000) begin
            errTotal++;
            testDone();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, `SIBW_IDX_BRK_CTRL, 8'h00);
        bus(1'b0, 16'hfe02, 8'h00);
        chk("watchdogEn", 32'h1, 32'(watchdogEn));
        for (int i = 0; i < 4; i++) begin
            rnd();
            srcReq <= v;
            bus(1'b1, `SIBW_IDX_FLAGS_LOW, 8'hff);
            bus(1'b0, `SIBW_IDX_FLAGS_LOW, {v[5:0], 2'b00});
            bus(1'b0, `SIBW_IDX_FLAGS_MID, v[13:6]);
            bus(1'b0, `SIBW_IDX_FLAGS_HIGH, {2'b00, v[19:14]});
        end
        srcReq <= 20'h0_0008;
        srcEn  <= 20'h7_ffff;
        wdOpt  <= 1'b1;
        expTake.push_back(7'h00);
        doOp(2'h1);
        waitTake(0);
        repeat (20) @(posedge mclk);
        chk("watchdogEn", 32'h0, 32'(watchdogEn));
        expTake.push_back(7'h44);
        doOp(2'h3);
        waitTake(0);
        for (int i = 0; i < 6; i++) begin
            rnd();
            a = v[4:0] % 19;
            b = (a + 1 + v[9:5] % 18) % 19;
            if (a > b) {a, b} = {b, a};
            slow <= v[10];
            expTake.push_back({2'b10, 5'(a + 1)});
            expTake.push_back({2'b10, 5'(b + 1)});
            srcReq <= (20'h1 << a) | (20'h1 << b) | 20'h8_0000;
            waitTake(1);
            waitTake(0);
        end
        srcReq <= '0;
        doOp(2'h2);
        repeat (3) @(posedge mclk);
        chk("cpuClkEn", 32'h0, 32'(cpuClkEn));
        chk("periphClkEn", 32'h1, 32'(periphClkEn));
        expTake.push_back(7'h4b);
        srcReq[10] <= 1'b1;
        waitTake(0);
        chk("cpuClkEn", 32'h1, 32'(cpuClkEn));
        doOp(2'h2);
        repeat (3) @(posedge mclk);
        expTake.push_back(7'h00);
        breakReq <= 1'b1;
        waitTake(0);
        breakReq <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("breakActive", 32'h1, 32'(breakActive));
        chk("flagClearEn", 32'h0, 32'(clrEn));
        bus(1'b0, `SIBW_IDX_BRK_STAT, 8'h02);
        bus(1'b1, `SIBW_IDX_BRK_CTRL, 8'h80);
        bus(1'b0, `SIBW_IDX_BRK_CTRL, 8'h80);
        chk("flagClearEn", 32'h1, 32'(clrEn));
        expTake.push_back(7'h00);
        doOp(2'h1);
        waitTake(0);
        repeat (2) @(posedge mclk);
        chk("breakActive", 32'h0, 32'(breakActive));
        bus(1'b1, `SIBW_IDX_BRK_STAT, 8'h00);
        bus(1'b0, `SIBW_IDX_BRK_STAT, 8'h00);
        testDone();
    end
endmodule : sibw_top_test
